// ### rtl/tmsl_consts.vh
// Purpose: Constants for the touch matrix setup loader.
// Assumes: 100 MHz clock, 32-bit APB register access.
// Notes: Setup block byte layout, defaults and register offsets.
`ifndef TMSL_CONSTS_VH
`define TMSL_CONSTS_VH
`define TMSL_NKEYS 24
`define TMSL_BLK_LEN 7'd101
`define TMSL_OFS_THR 7'd0
`define TMSL_OFS_DIL 7'd24
`define TMSL_OFS_RCL 7'd48
`define TMSL_OFS_BST 7'd72
`define TMSL_OFS_MSY 7'd96
`define TMSL_OFS_BSP 7'd97
`define TMSL_OFS_FLR_LO 7'd98
`define TMSL_OFS_FLR_HI 7'd99
`define TMSL_OFS_CRC 7'd100
`define TMSL_DEF_THR 8'hA6
`define TMSL_DEF_DIL 8'h52
`define TMSL_DEF_RCL 8'h14
`define TMSL_DEF_BST 8'h20
`define TMSL_DEF_MSY 8'h00
`define TMSL_DEF_BSP 8'h01
`define TMSL_DEF_FLR 16'h0064
`define TMSL_FLR_MAX 16'h07FF
`define TMSL_THR_ADD 8'h04
`define TMSL_CMD_SETUP 8'h01
`define TMSL_CMD_ALLKEYS 8'h07
`define TMSL_MSY_BIT 6
`define TMSL_NKS_BIT 6
`define TMSL_SSY_BIT 7
`define TMSL_BLEN_LSB 4
`define TMSL_A_CMD 12'h000
`define TMSL_A_DATA 12'h004
`define TMSL_A_STAT 12'h008
`define TMSL_A_REPORT 12'h00C
`define TMSL_A_KEYSEL 12'h010
`define TMSL_A_KEYCFG 12'h014
`define TMSL_A_GLOBAL 12'h018
`define TMSL_A_REF 12'h01C
`define TMSL_A_TOUCH 12'h020
`define TMSL_A_RECAL 12'h024
`endif

// ### rtl/tmsl_key_unit.v
// Purpose: Per-key setup storage with lookup translation and floor check.
// Assumes: Bytes arrive one at a time with a commit strobe after check.
// Notes: One instance per key; staging and live copies kept separately.
`timescale 1ns/1ns
`include "tmsl_consts.vh"
module tmsl_key_unit (
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire [1:0] stage_sel_i,
    input wire stage_we_i,
    input wire [7:0] stage_byte_i,
    input wire commit_i,
    input wire recal_i,
    input wire [15:0] floor_i,
    input wire [15:0] ref_i,
    output wire [31:0] cfg_o,
    output wire below_o
);
    // Staging bytes: threshold/drift, integrators, recal, burst/flags.
    reg [7:0] stg_r [0:3];
    // Live bytes used by the acquisition logic.
    reg [7:0] live_r [0:3];
    // Scope trigger only changes on reset or recalibration.
    reg scope_r;
    integer i;

    // Staging and live copies; the live copy changes only on reset or commit.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            stg_r[0] <= `TMSL_DEF_THR;
            stg_r[1] <= `TMSL_DEF_DIL;
            stg_r[2] <= `TMSL_DEF_RCL;
            stg_r[3] <= `TMSL_DEF_BST;
            live_r[0] <= `TMSL_DEF_THR;
            live_r[1] <= `TMSL_DEF_DIL;
            live_r[2] <= `TMSL_DEF_RCL;
            live_r[3] <= `TMSL_DEF_BST;
            scope_r <= 1'b0;
        end else if (ce_i) begin
            if (stage_we_i) begin
                stg_r[stage_sel_i] <= stage_byte_i;
            end
            if (commit_i) begin
                for (i = 0; i < 4; i = i + 1) begin
                    live_r[i] <= stg_r[i];
                end
            end
            if (recal_i) begin
                scope_r <= live_r[3][`TMSL_SSY_BIT];
            end
        end
    end

    // Drift compensation lookup, index 0..15 to seconds code.
    reg [7:0] drift_v;
    always @* begin
        case (live_r[0][7:4])
            4'h0: drift_v = 8'h01;
            4'h1: drift_v = 8'h02;
            4'h2: drift_v = 8'h03;
            4'h3: drift_v = 8'h04;
            4'h4: drift_v = 8'h05;
            4'h5: drift_v = 8'h06;
            4'h6: drift_v = 8'h07;
            4'h7: drift_v = 8'h08;
            4'h8: drift_v = 8'h09;
            4'h9: drift_v = 8'h0A;
            4'hA: drift_v = 8'h0A;
            default: drift_v = 8'h0A;
        endcase
    end

    // Burst length table: 16, 32, 48, 64 pulses.
    // The index plus one needs a third bit, or setting 3 would wrap to zero pulses.
    wire [2:0] blen_idx = {1'b0, live_r[3][`TMSL_BLEN_LSB+1:`TMSL_BLEN_LSB]} + 3'd1;
    wire [6:0] burst_v = {blen_idx, 4'h0};
    wire [7:0] thr_v = {4'h0, live_r[0][3:0]} + `TMSL_THR_ADD;
    wire key_on = (live_r[1][3:0] != 4'h0);

    // Packed view: threshold, drift, burst, flags, enable, integrators.
    assign cfg_o = {thr_v[5:0], drift_v[3:0], burst_v, live_r[3][`TMSL_NKS_BIT], scope_r,
                    key_on, live_r[1][7:4], live_r[1][3:0], 4'h0};
    // A disabled key cannot raise the floor error.
    assign below_o = key_on && (ref_i < floor_i);
endmodule

// ### rtl/tmsl_loader.v
// Purpose: Receive, check and apply the 101-byte touch matrix setup block.
// Assumes: APB master with 32-bit data; inputs synchronous to mclk_i.
// Notes: Setup mode is entered by two consecutive 0x01 commands.
// Function
// - Flag error when any reference below floor; the code ignores keys whose normal integrator is zero.
// - Floor limit two bytes, low byte first.
// - Floor default 100, range 0 to 2047.
// - Checksum byte at position 100 ends block.
// - Accept block only after two 0x01 commands.
// - Block is always 101 bytes long.
// - Threshold nibble plus four; drift via table.
// - Normal integrator zero disables the key.
// - Recal delay half seconds, zero infinite; the code stages the recal byte but nothing reads it.
// - Bits 5:4 choose burst length by table.
// - Bit 6 suppression, bit 7 scope sync.
// - Byte 96 bit 6 enables mains lock.
// - Byte 97 low nibble sets burst spacing.
// - Bytes 98-99 hold global signal floor.
// - Report command returns three touch bytes.
// - Byte is Y line, bit is X line.
// - Keys 0 to 7 byte sent first.
// - Field indexes translated through lookup tables.
// - Scope sync changes after reset or recal.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "tmsl_consts.vh"
module tmsl_loader (
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    output wire floor_error_o,
    output wire mains_lock_enable_o,
    output wire [3:0] burst_slot_spacing_o,
    output wire [15:0] signal_floor_limit_o,
    output wire setup_mode_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ARMED = 2'd1;
    localparam ST_LOAD = 2'd2;

    // Loader state, byte counter and running checksum.
    reg [1:0] state_r;
    reg [6:0] cnt_r;
    reg [7:0] sum_r;
    // Global staging and live bytes.
    reg [7:0] msy_stg_r;
    reg [7:0] bsp_stg_r;
    reg [15:0] floor_stg_r;
    reg [7:0] msy_r;
    reg [7:0] bsp_r;
    reg [15:0] floor_r;
    // Status: sticky checksum error, last load good, floor error.
    reg crc_err_r;
    reg load_ok_r;
    reg floor_err_r;
    // Report byte pointer for the three-byte touch stream.
    reg [1:0] rep_ptr_r;
    // Test-visible acquisition inputs and key selection.
    reg [4:0] key_sel_r;
    reg [15:0] ref_r [0:`TMSL_NKEYS-1];
    reg [`TMSL_NKEYS-1:0] touch_r;
    reg [`TMSL_NKEYS-1:0] recal_r;
    integer k;

    // APB decode: a transfer completes in its first access cycle.
    wire acc = psel_i && penable_i && ce_i;
    wire wr = acc && pwrite_i;
    wire rd = acc && !pwrite_i;
    wire a_cmd = (paddr_i == `TMSL_A_CMD);
    wire a_data = (paddr_i == `TMSL_A_DATA);
    wire a_stat = (paddr_i == `TMSL_A_STAT);
    wire a_rep = (paddr_i == `TMSL_A_REPORT);
    wire a_ksel = (paddr_i == `TMSL_A_KEYSEL);
    wire a_kcfg = (paddr_i == `TMSL_A_KEYCFG);
    wire a_glob = (paddr_i == `TMSL_A_GLOBAL);
    wire a_ref = (paddr_i == `TMSL_A_REF);
    wire a_touch = (paddr_i == `TMSL_A_TOUCH);
    wire a_recal = (paddr_i == `TMSL_A_RECAL);
    wire mapped = a_cmd | a_data | a_stat | a_rep | a_ksel | a_kcfg | a_glob |
                  a_ref | a_touch | a_recal;
    assign pready_o = 1'b1;
    // Unmapped addresses answer with an error and no side effect.
    assign pslverr_o = psel_i && penable_i && !mapped;

    wire [7:0] in_byte = pwdata_i[7:0];
    // A data byte is taken only while loading; others are ignored.
    wire take = wr && a_data && (state_r == ST_LOAD);
    wire last = (cnt_r == `TMSL_OFS_CRC);
    wire good = (sum_r == in_byte);
    wire commit = take && last && good;
    wire in_keys = (cnt_r < `TMSL_OFS_MSY);
    // Which key byte slot and which key the current byte belongs to.
    reg [1:0] slot_v;
    reg [6:0] key_v;
    always @* begin
        if (cnt_r < `TMSL_OFS_DIL) begin
            slot_v = 2'd0;
            key_v = cnt_r;
        end else if (cnt_r < `TMSL_OFS_RCL) begin
            slot_v = 2'd1;
            key_v = cnt_r - `TMSL_OFS_DIL;
        end else if (cnt_r < `TMSL_OFS_BST) begin
            slot_v = 2'd2;
            key_v = cnt_r - `TMSL_OFS_RCL;
        end else begin
            slot_v = 2'd3;
            key_v = cnt_r - `TMSL_OFS_BST;
        end
    end

    // Per-key units: configuration and floor comparison.
    wire [31:0] cfg_w [0:`TMSL_NKEYS-1];
    wire [`TMSL_NKEYS-1:0] below_w;
    genvar g;
    generate
        for (g = 0; g < `TMSL_NKEYS; g = g + 1) begin : g_key
            tmsl_key_unit tmsl_key_unit_inst (
                .mclk_i(mclk_i),
                .reset_n_i(reset_n_i),
                .ce_i(ce_i),
                .stage_sel_i(slot_v),
                .stage_we_i(take && in_keys && (key_v == g)),
                .stage_byte_i(in_byte),
                .commit_i(commit),
                .recal_i(recal_r[g]),
                .floor_i(floor_r),
                .ref_i(ref_r[g]),
                .cfg_o(cfg_w[g]),
                .below_o(below_w[g])
            );
        end
    endgenerate

    // Setup mode sequence: two consecutive 0x01 commands arm the load.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 7'd0;
            sum_r <= 8'h00;
        end else if (ce_i) begin
            case (state_r)
                ST_IDLE: begin
                    if (wr && a_cmd && (in_byte == `TMSL_CMD_SETUP)) begin
                        state_r <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // Any other command breaks the pair.
                    if (wr && a_cmd) begin
                        if (in_byte == `TMSL_CMD_SETUP) begin
                            state_r <= ST_LOAD;
                            cnt_r <= 7'd0;
                            sum_r <= 8'h00;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_LOAD: begin
                    if (take) begin
                        // Simple additive sum; the real polynomial is not modelled.
                        sum_r <= sum_r + in_byte;
                        cnt_r <= cnt_r + 7'd1;
                        if (last) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Global settings: staged during the load, applied on good checksum.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            msy_stg_r <= `TMSL_DEF_MSY;
            bsp_stg_r <= `TMSL_DEF_BSP;
            floor_stg_r <= `TMSL_DEF_FLR;
            msy_r <= `TMSL_DEF_MSY;
            bsp_r <= `TMSL_DEF_BSP;
            floor_r <= `TMSL_DEF_FLR;
        end else if (ce_i) begin
            if (take) begin
                if (cnt_r == `TMSL_OFS_MSY) begin
                    msy_stg_r <= in_byte;
                end else if (cnt_r == `TMSL_OFS_BSP) begin
                    bsp_stg_r <= in_byte;
                end else if (cnt_r == `TMSL_OFS_FLR_LO) begin
                    floor_stg_r[7:0] <= in_byte;
                end else if (cnt_r == `TMSL_OFS_FLR_HI) begin
                    floor_stg_r[15:8] <= in_byte;
                end
            end
            if (commit) begin
                msy_r <= msy_stg_r;
                bsp_r <= bsp_stg_r;
                // Values above 2047 are clamped to the top of the range.
                floor_r <= (floor_stg_r > `TMSL_FLR_MAX) ? `TMSL_FLR_MAX : floor_stg_r;
            end
        end
    end

    // Status flags; a fresh event wins over a clear by status write.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            crc_err_r <= 1'b0;
            load_ok_r <= 1'b0;
            floor_err_r <= 1'b0;
        end else if (ce_i) begin
            if (take && last && !good) begin
                crc_err_r <= 1'b1;
                load_ok_r <= 1'b0;
            end else if (wr && a_stat && pwdata_i[1]) begin
                crc_err_r <= 1'b0;
            end
            if (commit) begin
                load_ok_r <= 1'b1;
            end
            // Floor error follows the live comparison in every cycle with ce_i high.
            floor_err_r <= |below_w;
        end
    end

    // Acquisition stand-ins written by software: references, touches, recal.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            key_sel_r <= 5'd0;
            touch_r <= {`TMSL_NKEYS{1'b0}};
            recal_r <= {`TMSL_NKEYS{1'b0}};
            rep_ptr_r <= 2'd0;
            for (k = 0; k < `TMSL_NKEYS; k = k + 1) begin
                ref_r[k] <= 16'h0000;
            end
        end else if (ce_i) begin
            recal_r <= {`TMSL_NKEYS{1'b0}};
            if (wr && a_ksel) begin
                key_sel_r <= pwdata_i[4:0];
            end
            if (wr && a_ref && (key_sel_r < `TMSL_NKEYS)) begin
                ref_r[key_sel_r] <= pwdata_i[15:0];
            end
            if (wr && a_touch) begin
                touch_r <= pwdata_i[`TMSL_NKEYS-1:0];
            end
            if (wr && a_recal) begin
                recal_r <= pwdata_i[`TMSL_NKEYS-1:0];
            end
            // Report command restarts the stream at the keys 0..7 byte.
            if (wr && a_cmd && (in_byte == `TMSL_CMD_ALLKEYS)) begin
                rep_ptr_r <= 2'd0;
            end else if (rd && a_rep) begin
                rep_ptr_r <= (rep_ptr_r == 2'd2) ? 2'd0 : rep_ptr_r + 2'd1;
            end
        end
    end

    // Read mux: data is registered, so reads answer in the access cycle.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
            if (a_stat) begin
                prdata_o <= {26'h0, state_r, setup_mode_o, floor_err_r, crc_err_r,
                             load_ok_r};
            end else if (a_rep) begin
                // Byte index is Y line, bit index is X line.
                prdata_o <= {24'h0, touch_r[rep_ptr_r*8 +: 8]};
            end else if (a_ksel) begin
                prdata_o <= {27'h0, key_sel_r};
            end else if (a_kcfg) begin
                prdata_o <= (key_sel_r < `TMSL_NKEYS) ? cfg_w[key_sel_r] : 32'h0000_0000;
            end else if (a_glob) begin
                prdata_o <= {floor_r, 3'h0, msy_r[`TMSL_MSY_BIT], bsp_r[3:0], 8'h00};
            end else if (a_touch) begin
                prdata_o <= {8'h00, touch_r};
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    assign setup_mode_o = (state_r == ST_LOAD);
    assign floor_error_o = floor_err_r;
    assign mains_lock_enable_o = msy_r[`TMSL_MSY_BIT];
    assign burst_slot_spacing_o = bsp_r[3:0];
    assign signal_floor_limit_o = floor_r;
endmodule

// ### verification/tmsl_loader_asserts.sv
// Purpose: Port-level checks for the touch matrix setup loader.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to every loader instance below.
`timescale 1ns/1ns
module tmsl_loader_asserts (
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    input wire floor_error_o,
    input wire mains_lock_enable_o,
    input wire [3:0] burst_slot_spacing_o,
    input wire [15:0] signal_floor_limit_o,
    input wire setup_mode_o
);
    // Only transfers taken with the clock enable high count.
    wire acc = ce_i && psel_i && penable_i && pwrite_i;
    wire data_wr = acc && paddr_i == 12'h004;
    wire cmd_setup = acc && paddr_i == 12'h000 && pwdata_i[7:0] == 8'h01;
    // Bytes taken in the current load, so the block length is visible.
    reg [6:0] byte_cnt_r;
    always @(posedge mclk_i) begin
        if (!reset_n_i || !setup_mode_o) begin
            byte_cnt_r <= 7'h00;
        end else if (data_wr) begin
            byte_cnt_r <= byte_cnt_r + 7'h01;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    setup_entry_a: assert property (
        $rose(setup_mode_o) |-> $past(cmd_setup))
        else $error("setup mode entered without a setup command");
    block_len_a: assert property (
        $fell(setup_mode_o) && $past(reset_n_i) |-> byte_cnt_r == 7'h65)
        else $error("setup mode left before the full block");
    apply_point_a: assert property (
        $past(reset_n_i) && $changed({mains_lock_enable_o, burst_slot_spacing_o,
        signal_floor_limit_o}) |-> $fell(setup_mode_o) && $past(data_wr))
        else $error("settings changed outside block end");
    floor_max_a: assert property (
        signal_floor_limit_o <= 16'h07FF)
        else $error("floor limit above range");
    reset_dflt_a: assert property (
        $rose(reset_n_i) |-> signal_floor_limit_o == 16'h0064
        && burst_slot_spacing_o == 4'h1 && !mains_lock_enable_o)
        else $error("wrong settings after reset");
    reset_floor_a: assert property (
        $rose(reset_n_i) && ce_i |-> ##[1:2] floor_error_o)
        else $error("zero references not flagged");
    unmapped_err_a: assert property (
        psel_i && penable_i && paddr_i > 12'h024 |-> pslverr_o)
        else $error("unmapped access not refused");
    read_hold_a: assert property (
        psel_i && penable_i && !pwrite_i |=> $stable(prdata_o))
        else $error("read data moved after access");
    cover property ($fell(setup_mode_o));
    cover property ($rose(floor_error_o));
    cover property (psel_i && penable_i && pslverr_o);
endmodule
bind tmsl_loader tmsl_loader_asserts tmsl_loader_asserts_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .floor_error_o(floor_error_o), .mains_lock_enable_o(mains_lock_enable_o),
    .burst_slot_spacing_o(burst_slot_spacing_o),
    .signal_floor_limit_o(signal_floor_limit_o), .setup_mode_o(setup_mode_o)
);

// ### verification/tmsl_host_model.sv
// Purpose: Host model that sends commands and setup blocks over APB.
// Assumes: Called right after a rising edge; waits for pready.
// Notes: Released lines show inverted values so stale data never passes.
`timescale 1ns/1ns
`include "tmsl_consts.vh"
module tmsl_host_model (
    input wire mclk_i,
    input wire pready_i,
    input wire [31:0] prdata_i,
    input wire pslverr_i,
    output reg psel_o,
    output reg penable_o,
    output reg pwrite_o,
    output reg [11:0] paddr_o,
    output reg [31:0] pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
    end
    // One transfer: setup, access until pready, then release.
    task automatic xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q, output e);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do @(posedge mclk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
        @(posedge mclk_i);
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input [11:0] a, output [31:0] q, output e);
        xfer(a, 1'b0, 32'h0000_0000, q, e);
    endtask
    // Full load; key 0 is switched off and key 1 gets odd settings.
    task automatic load(input [15:0] fl, input bad);
        logic [7:0] b [0:100];
        logic [7:0] sum;
        for (int i = 0; i < 24; i++) begin
            b[i] = 8'hA6;
            b[i + 24] = 8'h52;
            b[i + 48] = 8'h14;
            b[i + 72] = 8'h20;
        end
        b[1] = 8'h0F;
        b[24] = 8'h50;
        b[73] = 8'hF0;
        b[96] = 8'h40;
        b[97] = 8'h03;
        b[98] = fl[7:0];
        b[99] = fl[15:8];
        sum = 8'h00;
        for (int i = 0; i < 100; i++) sum = sum + b[i];
        b[100] = sum ^ {7'h00, bad};
        wr(`TMSL_A_CMD, 32'h0000_0001);
        wr(`TMSL_A_CMD, 32'h0000_0001);
        for (int i = 0; i <= 100; i++) wr(`TMSL_A_DATA, {24'h00_0000, b[i]});
    endtask
endmodule

// ### verification/tmsl_loader_tb.sv
// Purpose: Self-checking bench for the touch matrix setup loader.
// Assumes: Host model drives APB; the bench drives reset and enable.
// Notes: Each scenario task judges its own results.
`timescale 1ns/1ns
`include "tmsl_consts.vh"
module tmsl_loader_tb;
    reg mclk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg ce_i = 1'b1;
    wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o, floor_error_o;
    wire mains_lock_enable_o, setup_mode_o;
    wire [11:0] paddr_i;
    wire [31:0] pwdata_i, prdata_o;
    wire [3:0] burst_slot_spacing_o;
    wire [15:0] signal_floor_limit_o;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    tmsl_loader tmsl_loader_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .floor_error_o(floor_error_o),
        .mains_lock_enable_o(mains_lock_enable_o), .setup_mode_o(setup_mode_o),
        .burst_slot_spacing_o(burst_slot_spacing_o),
        .signal_floor_limit_o(signal_floor_limit_o));
    tmsl_host_model tmsl_host_model_inst (.mclk_i(mclk_i), .pready_i(pready_o),
        .prdata_i(prdata_o), .pslverr_i(pslverr_o), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // A hang counts as a mismatch and ends the run.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        tmsl_host_model_inst.wr(a, d);
    endtask
    task rdr(input [11:0] a);
        tmsl_host_model_inst.rd(a, rd, err);
    endtask
    task complete_run;
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task t_defaults;
        chk("ready", 1'b1, pready_o);
        chk("floor", 16'h0064, signal_floor_limit_o);
        chk("spacing", 4'h1, burst_slot_spacing_o);
        chk("mains", 1'b0, mains_lock_enable_o);
        wr(`TMSL_A_KEYSEL, 32'h0000_0000);
        rdr(`TMSL_A_KEYCFG);
        chk("thr", 6'h0A, rd[31:26]);
        chk("nint", 4'h2, rd[7:4]);
        chk("fint", 4'h5, rd[11:8]);
        chk("burst", 7'h30, rd[21:15]);
        chk("flags", 3'h1, rd[14:12]);
    endtask
    task t_pair;
        wr(`TMSL_A_CMD, 32'h0000_0001);
        wr(`TMSL_A_CMD, 32'h0000_0007);
        wr(`TMSL_A_CMD, 32'h0000_0001);
        chk("split pair", 1'b0, setup_mode_o);
        wr(`TMSL_A_DATA, 32'h0000_0055);
        chk("stray byte", 16'h0064, signal_floor_limit_o);
        ce_i <= 1'b0;
        wr(`TMSL_A_CMD, 32'h0000_0001);
        ce_i <= 1'b1;
        chk("frozen", 1'b0, setup_mode_o);
        wr(`TMSL_A_CMD, 32'h0000_0007);
    endtask
    task t_good;
        tmsl_host_model_inst.load(16'h0123, 1'b0);
        chk("mode", 1'b0, setup_mode_o);
        chk("floor", 16'h0123, signal_floor_limit_o);
        chk("mains", 1'b1, mains_lock_enable_o);
        chk("spacing", 4'h3, burst_slot_spacing_o);
        rdr(`TMSL_A_GLOBAL);
        chk("global", 32'h0123_1300, rd & 32'hFFFF_1F00);
        rdr(`TMSL_A_STAT);
        chk("load ok", 1'b1, rd[0]);
        rdr(`TMSL_A_KEYCFG);
        chk("key0 off", 1'b0, rd[12]);
        wr(`TMSL_A_KEYSEL, 32'h0000_0001);
        rdr(`TMSL_A_KEYCFG);
        chk("thr1", 6'h13, rd[31:26]);
        chk("burst1", 7'h40, rd[21:15]);
        chk("supp1", 2'h2, rd[14:13]);
        wr(`TMSL_A_RECAL, 32'h0000_0002);
        rdr(`TMSL_A_KEYCFG);
        chk("sync1", 1'b1, rd[13]);
    endtask
    task t_report;
        wr(`TMSL_A_TOUCH, 32'h0008_5A81);
        rdr(`TMSL_A_TOUCH);
        chk("touch", 32'h0008_5A81, rd);
        wr(`TMSL_A_CMD, 32'h0000_0007);
        rdr(`TMSL_A_REPORT);
        chk("byte0", 8'h81, rd[7:0]);
        rdr(`TMSL_A_REPORT);
        chk("byte1", 8'h5A, rd[7:0]);
        rdr(`TMSL_A_REPORT);
        chk("key19", 8'h08, rd[7:0]);
        rdr(`TMSL_A_REPORT);
        chk("wrap", 8'h81, rd[7:0]);
    endtask
    task t_floor;
        for (int k = 1; k < 24; k++) begin
            wr(`TMSL_A_KEYSEL, k);
            wr(`TMSL_A_REF, 32'h0000_0123);
        end
        repeat (2) @(posedge mclk_i);
        chk("floor met", 1'b0, floor_error_o);
        wr(`TMSL_A_KEYSEL, 32'h0000_0005);
        wr(`TMSL_A_REF, 32'h0000_0122);
        repeat (2) @(posedge mclk_i);
        chk("floor low", 1'b1, floor_error_o);
        rdr(`TMSL_A_STAT);
        chk("stat floor", 1'b1, rd[2]);
    endtask
    task t_bad;
        tmsl_host_model_inst.load(16'h0200, 1'b1);
        chk("kept floor", 16'h0123, signal_floor_limit_o);
        rdr(`TMSL_A_STAT);
        chk("sum err", 1'b1, rd[1]);
        wr(`TMSL_A_STAT, 32'h0000_0002);
        rdr(`TMSL_A_STAT);
        chk("sum clr", 1'b0, rd[1]);
    endtask
    task t_clamp;
        tmsl_host_model_inst.load(16'h0800, 1'b0);
        chk("clamp", 16'h07FF, signal_floor_limit_o);
        rdr(12'h040);
        chk("unmapped", 1'b1, err);
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        t_defaults();
        t_pair();
        t_good();
        t_report();
        t_floor();
        t_bad();
        t_clamp();
        complete_run();
    end
endmodule
